// ==== include/cmac_pkg.sv ====
package cmac_pkg;

   // byte offsets of single registers, and region codes compared with address bits 7:5
   localparam logic [7:0] OFF_STATUS   = 8'h20;
   localparam logic [7:0] OFF_INSTR_LO = 8'h24;
   localparam logic [7:0] OFF_INSTR_HI = 8'h28;
   localparam logic [7:0] OFF_ISSUE    = 8'h2C;
   localparam logic [7:0] OFF_AUX7     = 8'h30;
   localparam logic [7:0] OFF_AUX6     = 8'h34;
   localparam logic [7:0] OFF_CYCLES   = 8'h38;
   localparam logic [2:0] RGN_VREG     = 3'h0;
   localparam logic [2:0] RGN_XMEM     = 3'h2;
   localparam logic [2:0] RGN_YMEM     = 3'h3;

   // status word fields
   localparam int PACK_BIT  = 0;
   localparam int RND_BIT   = 1;
   localparam int SAT_BIT   = 2;
   localparam int SHIFT_LSB = 3;
   localparam int SHIFT_MSB = 7;
   localparam int REAL_OVERFLOW_FLAG_BIT  = 8;
   localparam int IMAG_OVERFLOW_FLAG_BIT  = 9;
   localparam int BUSY_BIT  = 16;
   localparam int BADOP_BIT = 17;

   // issue word fields
   localparam int COUNT_MSB    = 15;
   localparam int CLR_REAL_OVERFLOW_FLAG_BIT = 16;
   localparam int CLR_IMAG_OVERFLOW_FLAG_BIT = 17;
   localparam int CLR_BADOP_BIT = 18;

   // opcodes
   localparam logic [15:0] OP_REP_MAC_LO = 16'hE251;
   localparam logic [7:0]  OP_REP_MAC_HI = 8'h2F;
   localparam logic [15:0] OP_CMUL_LO    = 16'hE50E;
   localparam logic [15:0] OP_CMUL_ST_LO = 16'hE307;
   localparam logic [3:0]  OP_CMUL_ST_HI = 4'h1;

   // timing: one pipeline period in clock cycles, latency is two periods
   localparam int          PIPE_P_CYCLES = 1;
   localparam logic [15:0] LAT_CYCLES    = 16'(2 * PIPE_P_CYCLES);

   // reset values and saturation limits
   localparam logic [31:0] VREG_RST   = 32'h0000_0000;
   localparam logic [7:0]  CTRL_RST   = 8'h00;
   localparam logic [15:0] INSTR_RST  = 16'h0000;
   localparam logic [2:0]  PTR_RST    = 3'h0;
   localparam logic signed [33:0] SAT_MAX = 34'sh0_7FFF_FFFF;
   localparam logic signed [33:0] SAT_MIN = 34'sh3_8000_0000;

   typedef struct packed {
      logic        ovf;
      logic [31:0] val;
   } sum_t;

   typedef struct packed {
      logic [4:0] shift;
      logic       sat;
      logic       rnd;
      logic       pack;
   } ctrl_t;

   function automatic sum_t clamp32(input logic signed [33:0] s, input logic sat);
      sum_t r;
      r.ovf = (s > SAT_MAX) || (s < SAT_MIN);
      if (r.ovf && sat) begin
         r.val = s[33] ? SAT_MIN[31:0] : SAT_MAX[31:0];
      end else begin
         r.val = s[31:0];
      end
      return r;
   endfunction : clamp32

   // acc + (v >> sh), rounded to nearest when rnd is set
   function automatic sum_t acc_add(input logic [31:0] acc, input logic [31:0] v,
                                    input logic [4:0] sh, input logic rnd,
                                    input logic sat);
      logic signed [33:0] t;
      logic signed [33:0] s;
      t = 34'(signed'(v) >>> sh);
      if (rnd && (sh != 5'h00)) begin
         t = t + 34'(v[sh - 5'h01]);
      end
      s = 34'(signed'(acc)) + t;
      return clamp32(s, sat);
   endfunction : acc_add

endpackage : cmac_pkg

// ==== design/conj_product.sv ====
`timescale 1ns/100ps
module conj_product
   import cmac_pkg::*;
(
   input  wire logic [31:0] x_op,   // first packed operand
   input  wire logic [31:0] y_op,   // second packed operand
   input  wire logic        pack,   // 1: real part in low half
   input  wire logic        sat,    // clamp on overflow
   output sum_t             re,     // real product and overflow
   output sum_t             im      // imaginary product and overflow
);

   logic signed [15:0] xr;
   logic signed [15:0] xi;
   logic signed [15:0] yr;
   logic signed [15:0] yi;
   logic signed [31:0] p_rr;
   logic signed [31:0] p_ii;
   logic signed [31:0] p_ri;
   logic signed [31:0] p_ir;

   assign xr = pack ? x_op[15:0]  : x_op[31:16];
   assign xi = pack ? x_op[31:16] : x_op[15:0];
   assign yr = pack ? y_op[15:0]  : y_op[31:16];
   assign yi = pack ? y_op[31:16] : y_op[15:0];

   assign p_rr = xr * yr;
   assign p_ii = xi * yi;
   assign p_ri = xr * yi;
   assign p_ir = yr * xi;

   // two full-scale negative products overflow 32 bits, hence 34-bit sums
   assign re = clamp32(34'(p_rr) + 34'(p_ii), sat);
   assign im = clamp32(34'(p_ri) - 34'(p_ir), sat);

endmodule : conj_product

// ==== design/complex_conj_mac_unit.sv ====
//
// Overview of operation
// - accumulate target alternates, vreg5/vreg4 first
// - odd: vreg5+=vreg1, vreg4+=vreg0 shifted, rounded
// - even: vreg7+=vreg3, vreg6+=vreg2 shifted, rounded
// - each iteration forms new conjugate product
// - second input via aux pointer 7, pack order
// - first input memory operand, same pack order
// - vreg0..vreg3 overwritten as scratch
// - real overflow flag on real add overflow
// - imaginary overflow flag on imaginary add overflow
// - run takes two latencies plus N cycles; here one latency plus count+1 cycles
// - decode repeated MAC two-word opcode
// - decode single-word conjugate multiply opcode
// - 16-bit packed inputs, 32-bit results vreg3/vreg2
// - pack 0 product equations
// - pack 1 product equations
// - saturate enable clamps to 32-bit range
// - multiply sets real and imaginary overflow flags
// - parallel-store form stores selected vector register
// - store one cycle, multiply two periods
//
// Our own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module complex_conj_mac_unit (
   input  wire logic        MCLK,       // core clock, 25 MHz
   input  wire logic        RST_B,      // synchronous reset, active low
   input  wire logic        HSEL,       // slave select
   input  wire logic [31:0] HADDR,      // byte address
   input  wire logic [1:0]  HTRANS,     // transfer type
   input  wire logic        HWRITE,     // write when high
   input  wire logic [2:0]  HSIZE,      // word only
   input  wire logic [31:0] HWDATA,     // write data
   input  wire logic        HREADY,     // bus ready
   output logic             HREADYOUT,  // slave ready
   output logic [31:0]      HRDATA,     // read data
   output logic             HRESP,      // always OKAY
   output logic             BUSY,       // instruction in flight
   output logic             REAL_OVF,   // real overflow flag
   output logic             IMAG_OVF    // imaginary overflow flag
);
   import cmac_pkg::*;

   typedef enum {ST_IDLE, ST_MUL, ST_FILL, ST_RUN} state_t;

   ////////////////////////////////////////////////////////////////////////////
   // state

   logic [31:0] vreg_q [8];
   logic [31:0] xmem_q [8];
   logic [31:0] ymem_q [8];
   ctrl_t       ctrl_q;
   logic        real_overflow_flag_q;
   logic        imag_overflow_flag_q;
   logic        badop_q;
   logic [15:0] instr_lo_q;
   logic [15:0] instr_hi_q;
   logic [2:0]  aux7_q;
   logic [2:0]  aux6_q;
   state_t      state_q;
   state_t      state_d;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic [15:0] instr_cnt_q;
   logic        odd_q;
   sum_t        res_re_q;
   sum_t        res_im_q;
   logic [15:0] cycles_q;
   logic [15:0] cycles_run_q;
   logic [7:0]  addr_q;
   logic        wr_q;

   ////////////////////////////////////////////////////////////////////////////
   // bus decode

   logic        take;
   logic        busy;
   logic        wr_vreg;
   logic        wr_xmem;
   logic        wr_ymem;
   logic        wr_status;
   logic        wr_lo;
   logic        wr_hi;
   logic        wr_issue;
   logic        wr_aux7;
   logic        wr_aux6;
   logic [2:0]  widx;
   logic [7:0]  ra;
   logic [31:0] status_word;
   logic [31:0] rd_word;

   assign take      = HSEL && HTRANS[1] && HREADY;
   assign busy      = (state_q != ST_IDLE);
   assign widx      = addr_q[4:2];
   // array and pointer writes are dropped while a run owns them
   assign wr_vreg   = wr_q && (addr_q[7:5] == RGN_VREG) && !busy;
   assign wr_xmem   = wr_q && (addr_q[7:5] == RGN_XMEM) && !busy;
   assign wr_ymem   = wr_q && (addr_q[7:5] == RGN_YMEM) && !busy;
   assign wr_status = wr_q && (addr_q == OFF_STATUS);
   assign wr_lo     = wr_q && (addr_q == OFF_INSTR_LO) && !busy;
   assign wr_hi     = wr_q && (addr_q == OFF_INSTR_HI) && !busy;
   assign wr_issue  = wr_q && (addr_q == OFF_ISSUE);
   assign wr_aux7   = wr_q && (addr_q == OFF_AUX7) && !busy;
   assign wr_aux6   = wr_q && (addr_q == OFF_AUX6) && !busy;

   assign status_word = {14'h0000, badop_q, busy, 6'h00, imag_overflow_flag_q, real_overflow_flag_q, ctrl_q};
   assign ra = HADDR[7:0];
   assign rd_word =
      (ra[7:5] == RGN_VREG) ? vreg_q[ra[4:2]] :
      (ra[7:5] == RGN_XMEM) ? xmem_q[ra[4:2]] :
      (ra[7:5] == RGN_YMEM) ? ymem_q[ra[4:2]] :
      (ra == OFF_STATUS)    ? status_word :
      (ra == OFF_INSTR_LO)  ? {16'h0000, instr_lo_q} :
      (ra == OFF_INSTR_HI)  ? {16'h0000, instr_hi_q} :
      (ra == OFF_AUX7)      ? {29'h0000_0000, aux7_q} :
      (ra == OFF_AUX6)      ? {29'h0000_0000, aux6_q} :
      (ra == OFF_CYCLES)    ? {16'h0000, cycles_q} : 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // instruction decode

   logic is_mac;
   logic is_mul;
   logic is_mst;
   logic issue;
   logic issue_mac;
   logic issue_mul;
   logic st_ok;
   logic [2:0] st_src;
   logic [2:0] st_dst;

   assign is_mac = (instr_lo_q == OP_REP_MAC_LO)
                && (instr_hi_q[15:8] == OP_REP_MAC_HI);
   assign is_mul = (instr_lo_q == OP_CMUL_LO);
   assign is_mst = (instr_lo_q == OP_CMUL_ST_LO)
                && (instr_hi_q[15:12] == OP_CMUL_ST_HI);
   // a second issue during a run is ignored, software must poll busy;
   // a write carrying clear bits only clears, so the held opcode never reruns
   assign issue     = wr_issue && !busy && !HWDATA[CLR_REAL_OVERFLOW_FLAG_BIT]
                   && !HWDATA[CLR_IMAG_OVERFLOW_FLAG_BIT] && !HWDATA[CLR_BADOP_BIT];
   assign issue_mac = issue && is_mac;
   assign issue_mul = issue && (is_mul || is_mst);
   // source field above 7 names no vector register and stores nothing
   assign st_ok  = issue && is_mst && !instr_hi_q[11];
   assign st_src = instr_hi_q[10:8];
   assign st_dst = instr_hi_q[2:0];

   ////////////////////////////////////////////////////////////////////////////
   // datapath

   logic [31:0] x_in;
   logic [31:0] y_in;
   sum_t        prod_re;
   sum_t        prod_im;
   sum_t        acc_re;
   sum_t        acc_im;
   logic        run_step;

   assign run_step = (state_q == ST_RUN);
   // the run fetches from the operand arrays, plain multiply from vreg0/vreg1
   assign x_in = run_step ? xmem_q[aux6_q] : vreg_q[0];
   assign y_in = run_step ? ymem_q[aux7_q] : vreg_q[1];

   conj_product u_prod (
      .x_op (x_in),
      .y_op (y_in),
      .pack (ctrl_q.pack),
      .sat  (ctrl_q.sat),
      .re   (prod_re),
      .im   (prod_im)
   );

   // odd steps fold vreg1/vreg0 into vreg5/vreg4, even steps vreg3/vreg2
   assign acc_re = odd_q
      ? acc_add(vreg_q[5], vreg_q[1], ctrl_q.shift, ctrl_q.rnd, ctrl_q.sat)
      : acc_add(vreg_q[7], vreg_q[3], ctrl_q.shift, ctrl_q.rnd, ctrl_q.sat);
   assign acc_im = odd_q
      ? acc_add(vreg_q[4], vreg_q[0], ctrl_q.shift, ctrl_q.rnd, ctrl_q.sat)
      : acc_add(vreg_q[6], vreg_q[2], ctrl_q.shift, ctrl_q.rnd, ctrl_q.sat);

   logic commit_mul;
   logic set_real_overflow_flag;
   logic set_imag_overflow_flag;

   assign commit_mul = (state_q == ST_MUL) && (cnt_q == 16'h0000);
   assign set_real_overflow_flag = (commit_mul && res_re_q.ovf)
                  || (run_step && (acc_re.ovf || prod_re.ovf));
   assign set_imag_overflow_flag = (commit_mul && res_im_q.ovf)
                  || (run_step && (acc_im.ovf || prod_im.ovf));

   ////////////////////////////////////////////////////////////////////////////
   // sequencer

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      unique case (state_q)
         ST_IDLE: begin
            if (issue_mac) begin
               state_d = ST_FILL;
               cnt_d   = LAT_CYCLES - 16'h0001;
            end else if (issue_mul) begin
               state_d = ST_MUL;
               cnt_d   = LAT_CYCLES - 16'h0001;
            end
         end
         ST_MUL: begin
            if (cnt_q == 16'h0000) begin
               state_d = ST_IDLE;
            end else begin
               cnt_d = cnt_q - 16'h0001;
            end
         end
         ST_FILL: begin
            if (cnt_q == 16'h0000) begin
               state_d = ST_RUN;
               cnt_d   = instr_cnt_q;
            end else begin
               cnt_d = cnt_q - 16'h0001;
            end
         end
         ST_RUN: begin
            if (cnt_q == 16'h0000) begin
               state_d = ST_IDLE;
            end else begin
               cnt_d = cnt_q - 16'h0001;
            end
         end
      endcase
   end

   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         state_q     <= ST_IDLE;
         cnt_q       <= 16'h0000;
         instr_cnt_q <= 16'h0000;
         odd_q       <= 1'b1;
         BUSY        <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         BUSY    <= (state_d != ST_IDLE);
         if (issue_mac) begin
            instr_cnt_q <= HWDATA[COUNT_MSB:0];
            odd_q       <= 1'b1;
         end else if (run_step) begin
            odd_q <= !odd_q;
         end
      end
   end

   // cycles from issue to completion of the last run, shown to software
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         cycles_q     <= 16'h0000;
         cycles_run_q <= 16'h0000;
      end else if (issue) begin
         cycles_run_q <= 16'h0001;
      end else if (busy) begin
         cycles_run_q <= cycles_run_q + 16'h0001;
         if (state_d == ST_IDLE) begin
            cycles_q <= cycles_run_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // multiply result held for the pipeline latency

   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         res_re_q <= '0;
         res_im_q <= '0;
      end else if (issue_mul) begin
         res_re_q <= prod_re;
         res_im_q <= prod_im;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // vector registers

   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         for (int i = 0; i < 8; i++) begin
            vreg_q[i] <= VREG_RST;
         end
      end else if (commit_mul) begin
         vreg_q[3] <= res_re_q.val;
         vreg_q[2] <= res_im_q.val;
      end else if (run_step && odd_q) begin
         vreg_q[5] <= acc_re.val;
         vreg_q[4] <= acc_im.val;
         vreg_q[1] <= prod_re.val;
         vreg_q[0] <= prod_im.val;
      end else if (run_step) begin
         vreg_q[7] <= acc_re.val;
         vreg_q[6] <= acc_im.val;
         vreg_q[3] <= prod_re.val;
         vreg_q[2] <= prod_im.val;
      end else if (wr_vreg) begin
         vreg_q[widx] <= HWDATA;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // operand memory and pointers

   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         for (int i = 0; i < 8; i++) begin
            xmem_q[i] <= VREG_RST;
            ymem_q[i] <= VREG_RST;
         end
      end else begin
         if (st_ok) begin
            xmem_q[st_dst] <= vreg_q[st_src];
         end else if (wr_xmem) begin
            xmem_q[widx] <= HWDATA;
         end
         if (wr_ymem) begin
            ymem_q[widx] <= HWDATA;
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         aux7_q <= PTR_RST;
         aux6_q <= PTR_RST;
      end else if (run_step) begin
         aux7_q <= aux7_q + 3'h1;
         aux6_q <= aux6_q + 3'h1;
      end else begin
         if (wr_aux7) begin
            aux7_q <= HWDATA[2:0];
         end
         if (wr_aux6) begin
            aux6_q <= HWDATA[2:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control and status

   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         ctrl_q     <= CTRL_RST;
         instr_lo_q <= INSTR_RST;
         instr_hi_q <= INSTR_RST;
      end else begin
         // mode changes mid-run would mix conventions, so they are dropped
         if (wr_status && !busy) begin
            ctrl_q <= HWDATA[SHIFT_MSB:PACK_BIT];
         end
         if (wr_lo) begin
            instr_lo_q <= HWDATA[15:0];
         end
         if (wr_hi) begin
            instr_hi_q <= HWDATA[15:0];
         end
      end
   end

   // set beats clear in the same cycle
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         real_overflow_flag_q  <= 1'b0;
         imag_overflow_flag_q  <= 1'b0;
         badop_q <= 1'b0;
      end else begin
         if (set_real_overflow_flag) begin
            real_overflow_flag_q <= 1'b1;
         end else if (wr_issue && HWDATA[CLR_REAL_OVERFLOW_FLAG_BIT]) begin
            real_overflow_flag_q <= 1'b0;
         end
         if (set_imag_overflow_flag) begin
            imag_overflow_flag_q <= 1'b1;
         end else if (wr_issue && HWDATA[CLR_IMAG_OVERFLOW_FLAG_BIT]) begin
            imag_overflow_flag_q <= 1'b0;
         end
         if (issue && !(is_mac || is_mul || is_mst)
             && !HWDATA[CLR_REAL_OVERFLOW_FLAG_BIT] && !HWDATA[CLR_IMAG_OVERFLOW_FLAG_BIT]
             && !HWDATA[CLR_BADOP_BIT]) begin
            badop_q <= 1'b1;
         end else if (wr_issue && HWDATA[CLR_BADOP_BIT]) begin
            badop_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         REAL_OVF <= 1'b0;
         IMAG_OVF <= 1'b0;
      end else begin
         REAL_OVF <= real_overflow_flag_q;
         IMAG_OVF <= imag_overflow_flag_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus slave: zero wait states, read data registered in the address phase

   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         addr_q    <= 8'h00;
         wr_q      <= 1'b0;
         HRDATA    <= 32'h0000_0000;
         HREADYOUT <= 1'b0;
         HRESP     <= 1'b0;
      end else begin
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
         wr_q      <= take && HWRITE;
         if (take) begin
            addr_q <= HADDR[7:0];
         end
         if (take && !HWRITE) begin
            HRDATA <= rd_word;
         end
      end
   end

endmodule : complex_conj_mac_unit

// ==== testbench/cmac_asserts.sv ====
`timescale 1ns/100ps
module cmac_asserts
   import cmac_pkg::*;
(
   input  wire logic        MCLK,       // core clock
   input  wire logic        RST_B,      // synchronous reset, active low
   input  wire logic        HSEL,       // slave select
   input  wire logic [31:0] HADDR,      // byte address
   input  wire logic [1:0]  HTRANS,     // transfer type
   input  wire logic        HWRITE,     // write when high
   input  wire logic [31:0] HWDATA,     // write data
   input  wire logic        HREADY,     // bus ready
   input  wire logic        HREADYOUT,  // slave ready
   input  wire logic [31:0] HRDATA,     // read data
   input  wire logic        HRESP,      // response
   input  wire logic        BUSY,       // instruction in flight
   input  wire logic        REAL_OVF    // real overflow flag
);
   logic wr_issue_q;
   wire  rd_ap = HSEL && HTRANS[1] && HREADY && !HWRITE;
   // any clear request, busy or idle; the clear check adds !BUSY since a set wins over a clear
   wire  clr_r = wr_issue_q && HWDATA[CLR_REAL_OVERFLOW_FLAG_BIT];
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         wr_issue_q <= 1'b0;
      end else begin
         wr_issue_q <= HSEL && HTRANS[1] && HREADY && HWRITE && (HADDR[7:0] == OFF_ISSUE);
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_B);
   property p_ready; $past(RST_B) |-> HREADYOUT; endproperty
   a_ready: assert property (p_ready) else $error("slave not ready");
   property p_okay; HRESP == 1'b0; endproperty
   a_okay: assert property (p_okay) else $error("response not okay");
   property p_rdata_hold; $changed(HRDATA) |-> $past(rd_ap); endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");
   property p_busy_cause; $rose(BUSY) |-> $past(wr_issue_q) || $past(wr_issue_q, 2); endproperty
   a_busy_cause: assert property (p_busy_cause) else $error("busy without issue");
   property p_busy_len; $rose(BUSY) |-> BUSY[*2] ##[1:300] !BUSY; endproperty
   a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
   property p_real_overflow_flag_sticky; REAL_OVF && !clr_r && !$past(clr_r) |=> REAL_OVF; endproperty
   a_real_overflow_flag_sticky: assert property (p_real_overflow_flag_sticky) else $error("real flag dropped");
   property p_real_overflow_flag_clear; clr_r && !BUSY |-> ##2 !REAL_OVF; endproperty
   a_real_overflow_flag_clear: assert property (p_real_overflow_flag_clear) else $error("real flag not cleared");
   property p_real_overflow_flag_cause;
      $rose(REAL_OVF) |-> $past(BUSY) || $past(BUSY, 2) || $past(BUSY, 3);
   endproperty
   a_real_overflow_flag_cause: assert property (p_real_overflow_flag_cause) else $error("real flag while idle");
endmodule : cmac_asserts

bind complex_conj_mac_unit cmac_asserts chk_u (.MCLK(MCLK), .RST_B(RST_B), .HSEL(HSEL),
   .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
   .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP), .BUSY(BUSY), .REAL_OVF(REAL_OVF));

// ==== testbench/ahb_host.sv ====
`timescale 1ns/100ps
module ahb_host (
   input  wire logic        mclk,    // bus clock
   input  wire logic        hready,  // ready seen by the master
   input  wire logic [31:0] hrdata,  // read data
   output logic             hsel,    // slave select
   output logic [31:0]      haddr,   // byte address
   output logic [1:0]       htrans,  // transfer type
   output logic             hwrite,  // write when high
   output logic [2:0]       hsize,   // always a word
   output logic [31:0]      hwdata   // write data
);
   initial begin
      hsel   = 1'b0;
      haddr  = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize  = 3'h2;
      hwdata = 32'h0;
   end
   // single word transfer; entered just after a rising edge
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr  <= {24'h0, a};
      do @(posedge mclk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wr ? d : ~hwdata;
      do @(posedge mclk); while (hready !== 1'b1);
      q = hrdata;
      // released data lines must not keep looking valid
      hwdata <= ~hwdata;
   endtask : xfer
endmodule : ahb_host

// ==== testbench/tb.sv ====
`timescale 1ns/100ps
module tb;
   import cmac_pkg::*;
   logic        mclk, rst_b, hsel, hwrite, hreadyout, hresp, busy, real_ovf, imag_ovf, er;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] m [8], xa [8], ya [8], x, y;
   logic [65:0] p;
   int          n_errors = 0, checked = 0, nb, a6, a7, b;

   complex_conj_mac_unit dut_u (.MCLK(mclk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
      .HREADYOUT(hreadyout), .HRDATA(hrdata), .HRESP(hresp), .BUSY(busy),
      .REAL_OVF(real_ovf), .IMAG_OVF(imag_ovf));
   ahb_host host_u (.mclk(mclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [32:0] sat32(input logic signed [33:0] s, input logic en);
      logic ov;
      ov = (s[33:31] != {3{s[31]}});
      return {ov, (ov && en) ? (s[33] ? 32'h8000_0000 : 32'h7FFF_FFFF) : s[31:0]};
   endfunction : sat32
   function automatic logic [65:0] cprod(input logic [31:0] x, input logic [31:0] y,
                                         input logic pk, input logic en);
      logic signed [15:0] xr, xi, yr, yi;
      logic [32:0]        r, i;
      xr = pk ? x[15:0] : x[31:16];
      xi = pk ? x[31:16] : x[15:0];
      yr = pk ? y[15:0] : y[31:16];
      yi = pk ? y[31:16] : y[15:0];
      r = sat32(xr * yr + xi * yi, en);
      i = sat32(xr * yi - yr * xi, en);
      return {r[32], i[32], r[31:0], i[31:0]};
   endfunction : cprod
   function automatic logic [31:0] acc(input logic [31:0] a, input logic [31:0] v);
      logic [31:0] t;
      t = $signed(v) >>> 2;
      // round to nearest: add the last bit shifted out
      t = t + v[1];
      return a + t;
   endfunction : acc
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host_u.xfer(1'b1, a, d, q);
   endtask : wr
   task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
      host_u.xfer(1'b0, a, 32'h0, q);
      chk(nm, e, q);
   endtask : rc
   // waits for the end of the run and counts the busy cycles
   task automatic issue(input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] cnt);
      wr(OFF_INSTR_LO, {16'h0, lo});
      wr(OFF_INSTR_HI, {16'h0, hi});
      wr(OFF_ISSUE, {16'h0, cnt});
      nb = 1;
      @(posedge mclk);
      #1;
      while (busy !== 1'b0 && nb < 300) begin
         nb++;
         @(posedge mclk);
         #1;
      end
      @(posedge mclk);
   endtask : issue
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   initial begin
      #(40 * 20000);
      n_errors++;
      report_and_stop();
   end
   initial begin
      rst_b = 1'b0;
      er    = 1'b0;
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      rc("status", OFF_STATUS, 32'h0);
      wr(8'h80, 32'hFFFF_FFFF);
      rc("unmapped", 8'h80, 32'h0);
      wr(8'h1C, 32'hC0DE_0007);
      // overflow cases first so that the plain ones show the flag holding
      for (int c = 0; c < 4; c++) begin
         x = (c < 2) ? 32'h8000_8000 : 32'h0003_FFFE;
         y = (c < 2) ? 32'h8000_8000 : 32'hFFFB_0007;
         wr(OFF_STATUS, {29'h0, c == 0, 1'b0, c[0]});
         wr(8'h00, x);
         wr(8'h04, y);
         issue((c == 3) ? OP_CMUL_ST_LO : OP_CMUL_LO, (c == 3) ? 16'h1705 : 16'h0, 16'h0);
         chk("latency", 32'(LAT_CYCLES), nb);
         p  = cprod(x, y, c[0], c == 0);
         er = er | p[65];
         rc("vreg3", 8'h0C, p[63:32]);
         rc("vreg2", 8'h08, p[31:0]);
         chk("real_ovf", {31'h0, er}, {31'h0, real_ovf});
         chk("imag_ovf", 32'h0, {31'h0, imag_ovf});
      end
      rc("stored", {RGN_XMEM, 3'h5, 2'h0}, 32'hC0DE_0007);
      wr(OFF_ISSUE, 32'h0001_0000);
      rc("status", OFF_STATUS, 32'h0000_0001);
      chk("real_ovf", 32'h0, {31'h0, real_ovf});
      for (int i = 0; i < 8; i++) begin
         m[i]  = {4'(i), 28'h000_1236};
         xa[i] = 32'h0003_FFFE + 32'h0001_0000 * i;
         ya[i] = 32'hFFFB_0007 - i;
         wr(8'(4 * i), m[i]);
         wr({RGN_XMEM, i[2:0], 2'h0}, xa[i]);
         wr({RGN_YMEM, i[2:0], 2'h0}, ya[i]);
      end
      wr(OFF_STATUS, 32'h0000_0012);
      wr(OFF_AUX6, 32'h6);
      wr(OFF_AUX7, 32'h3);
      issue(OP_REP_MAC_LO, {OP_REP_MAC_HI, 8'h00}, 16'h0003);
      chk("mac_busy", 32'h6, nb);
      rc("cycles", OFF_CYCLES, 32'h6);
      a6 = 6;
      a7 = 3;
      for (int k = 1; k <= 4; k++) begin
         b        = k[0] ? 0 : 2;
         m[5 + b] = acc(m[5 + b], m[1 + b]);
         m[4 + b] = acc(m[4 + b], m[b]);
         p        = cprod(xa[a6], ya[a7], 1'b0, 1'b0);
         m[1 + b] = p[63:32];
         m[b]     = p[31:0];
         a6       = (a6 + 1) % 8;
         a7       = (a7 + 1) % 8;
      end
      for (int i = 0; i < 8; i++) begin
         rc("vreg", 8'(4 * i), m[i]);
      end
      rc("aux6", OFF_AUX6, 32'h2);
      rc("aux7", OFF_AUX7, 32'h7);
      report_and_stop();
   end
endmodule : tb
